// ==== rtl/dcf_pkg.sv ====
// Purpose: shared constants of the decimation filter and output format block
// Assumes: one core clock; mode pins are synchronous to it
// Notes:   all counts are in core clocks, modulator ticks or conversions
package dcf_pkg;
    // operating mode codes on the mode pins
    localparam logic [1:0]        MODE_HS     = 2'h0;
    localparam logic [1:0]        MODE_HR     = 2'h1;
    localparam logic [1:0]        MODE_LP     = 2'h2;
    localparam logic [1:0]        MODE_LS     = 2'h3;
    // modulator clock divide factors
    localparam int                DIV_W       = 6;
    localparam logic [DIV_W-1:0]  DIV_4       = 6'h04;
    localparam logic [DIV_W-1:0]  DIV_8       = 6'h08;
    localparam logic [DIV_W-1:0]  DIV_40      = 6'h28;
    // oversampling ratios
    localparam int                OSR_W       = 8;
    localparam logic [OSR_W-1:0]  OSR_HR      = 8'h80;
    localparam logic [OSR_W-1:0]  OSR_STD     = 8'h40;
    // scaling of the sinc3 gain to the 24-bit full scale
    localparam int                SCL_W       = 28;
    localparam logic [2:0]        SHIFT_HR    = 3'h2;
    localparam logic [2:0]        SHIFT_STD   = 3'h5;
    // result format
    localparam int                OUT_W       = 24;
    localparam logic [OUT_W-1:0]  POS_FULL    = 24'h7FFFFF;
    localparam logic [OUT_W-1:0]  NEG_FULL    = 24'h800000;
    // settling, in conversion periods
    localparam int                SETTLE_W    = 7;
    localparam logic [SETTLE_W-1:0] SETTLE_HR  = 7'h4E;
    localparam logic [SETTLE_W-1:0] SETTLE_STD = 7'h4C;
endpackage

// ==== rtl/dcf_top.sv ====
// Purpose: per-channel decimation and 24-bit output formatting of a delta-sigma converter
// Assumes: modulator bits are sampled on the modulator tick; mode pins synchronous
// Notes:   mode or divide change restarts the filter and the settle count
module dcf_top
    import dcf_pkg::*;
#(
    parameter int NCH   = 8,
    parameter int ACC_W = 26
)(
    input  wire logic                 core_clk,
    input  wire logic                 resetn,
    input  wire logic [1:0]           modeSel,
    input  wire logic                 clockDivideSelect,
    input  wire logic [NCH-1:0]       modBits,
    output logic                      modulatorRate,
    output logic [NCH*OUT_W-1:0]      resultData,
    output logic                      resultValid,
    output logic                      dataSettled
);

    function automatic logic [DIV_W-1:0] divFactor(input logic [1:0] m, input logic cd);
        logic [DIV_W-1:0] f;
        f = DIV_4;
        if (m == MODE_LP)
            f = cd ? DIV_8 : DIV_4;
        else if (m == MODE_LS)
            f = cd ? DIV_40 : DIV_8;
        return f;
    endfunction

    function automatic logic [OUT_W-1:0] satOut(input logic signed [SCL_W-1:0] x);
        logic [OUT_W-1:0] r;
        r = x[OUT_W-1:0];
        if (x > $signed({{(SCL_W-OUT_W){1'b0}}, POS_FULL}))
            r = POS_FULL;
        else if (x < $signed({{(SCL_W-OUT_W){1'b1}}, NEG_FULL}))
            r = NEG_FULL;
        return r;
    endfunction

    logic [DIV_W-1:0]    divCnt_q;
    logic [OSR_W-1:0]    decCnt_q;
    logic [1:0]          modeHeld_q;
    logic                divHeld_q;
    logic [SETTLE_W-1:0] convCnt_q;
    logic                modTick_q;
    logic                valid_q;
    logic                settled_q;
    logic [NCH*OUT_W-1:0] data_q;
    logic signed [ACC_W-1:0] int1_q [NCH];
    logic signed [ACC_W-1:0] int2_q [NCH];
    logic signed [ACC_W-1:0] int3_q [NCH];
    logic signed [ACC_W-1:0] dly1_q [NCH];
    logic signed [ACC_W-1:0] dly2_q [NCH];
    logic signed [ACC_W-1:0] dly3_q [NCH];
    logic signed [ACC_W-1:0] comb1 [NCH];
    logic signed [ACC_W-1:0] comb2 [NCH];
    logic signed [ACC_W-1:0] comb3 [NCH];

    // mode monitored continuously; any change restarts conversion
    wire                 restart    = (modeSel != modeHeld_q) || (clockDivideSelect != divHeld_q);
    wire [DIV_W-1:0]     divNow     = divFactor(modeSel, clockDivideSelect);
    wire                 isHr       = (modeSel == MODE_HR);
    wire [OSR_W-1:0]     osrNow     = isHr ? OSR_HR : OSR_STD;
    wire [2:0]           shiftNow   = isHr ? SHIFT_HR : SHIFT_STD;
    wire [SETTLE_W-1:0]  settleNow  = isHr ? SETTLE_HR : SETTLE_STD;
    wire                 modTick    = !restart && (divCnt_q == divNow - 1'b1);
    wire                 convTick   = modTick && (decCnt_q == osrNow - 1'b1);

    // comb section of the sinc3 filter; symmetric impulse response
    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            comb1[c] = int3_q[c] - dly1_q[c];
            comb2[c] = comb1[c] - dly2_q[c];
            comb3[c] = comb2[c] - dly3_q[c];
        end
    end

    // modulator rate and decimation counters, shared by all channels
    always_ff @(posedge core_clk)
    begin
        if (!resetn || restart || modTick)
            divCnt_q <= '0;
        else
            divCnt_q <= divCnt_q + 1'b1;
        if (!resetn || restart || convTick)
            decCnt_q <= '0;
        else if (modTick)
            decCnt_q <= decCnt_q + 1'b1;
        modeHeld_q <= resetn ? modeSel : MODE_HS;
        divHeld_q  <= resetn ? clockDivideSelect : 1'b0;
        modTick_q  <= resetn && modTick;
        valid_q    <= resetn && convTick;
    end

    // settle tracking in conversion periods
    always_ff @(posedge core_clk)
    begin
        if (!resetn || restart)
        begin
            convCnt_q <= '0;
            settled_q <= 1'b0;
        end
        else if (convTick && !settled_q)
        begin
            convCnt_q <= convCnt_q + 1'b1;
            settled_q <= (convCnt_q + 1'b1) == settleNow;
        end
    end

    // integrators at the modulator rate, combs and formatting at the output rate
    always_ff @(posedge core_clk)
    begin
        for (int c = 0; c < NCH; c++)
        begin
            if (!resetn || restart)
            begin
                int1_q[c] <= '0;
                int2_q[c] <= '0;
                int3_q[c] <= '0;
                dly1_q[c] <= '0;
                dly2_q[c] <= '0;
                dly3_q[c] <= '0;
            end
            else if (modTick)
            begin
                int1_q[c] <= int1_q[c] + (modBits[c] ? ACC_W'(1) : -ACC_W'(1));
                int2_q[c] <= int2_q[c] + int1_q[c];
                int3_q[c] <= int3_q[c] + int2_q[c];
                if (convTick)
                begin
                    dly1_q[c] <= int3_q[c];
                    dly2_q[c] <= comb1[c];
                    dly3_q[c] <= comb2[c];
                end
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            data_q <= '0;
        else if (convTick)
            for (int c = 0; c < NCH; c++)
                data_q[c*OUT_W +: OUT_W] <= satOut(SCL_W'(comb3[c]) <<< shiftNow);
    end

    assign modulatorRate = modTick_q;
    assign resultData    = data_q;
    assign resultValid   = valid_q;
    assign dataSettled   = settled_q;

    default clocking dcfCk @(posedge core_clk); endclocking
    default disable iff (!resetn);

    logic [OSR_W-1:0] ticksSinceConv_q;
    always_ff @(posedge core_clk)
    begin
        if (!resetn || restart || convTick)
            ticksSinceConv_q <= '0;
        else if (modTick)
            ticksSinceConv_q <= ticksSinceConv_q + 1'b1;
    end

    property p_osrHr;
        (convTick && isHr) |-> ticksSinceConv_q == OSR_HR - 1'b1;
    endproperty
    a_osrHr: assert property (p_osrHr) else $error("hr conversion not after 128 ticks");

    property p_osrStd;
        (convTick && !isHr) |-> ticksSinceConv_q == OSR_STD - 1'b1;
    endproperty
    a_osrStd: assert property (p_osrStd) else $error("conversion not after 64 ticks");

    property p_divHs;
        (modTick && modeSel == MODE_HS) ##1 !restart [*4] |-> modTick && !$past(modTick)
            && !$past(modTick, 2) && !$past(modTick, 3);
    endproperty
    a_divHs: assert property (p_divHs) else $error("hs modulator tick spacing wrong");

    property p_divLs;
        (modTick && modeSel == MODE_LS && clockDivideSelect) |=> !modTick [*8];
    endproperty
    a_divLs: assert property (p_divLs) else $error("ls modulator tick too early");

    property p_validAfterTick;
        resultValid |-> $past(convTick) && modulatorRate;
    endproperty
    a_validAfterTick: assert property (p_validAfterTick) else $error("result not on shared boundary");

    property p_settle;
        $rose(dataSettled) |-> convCnt_q == (modeHeld_q == MODE_HR ? SETTLE_HR : SETTLE_STD);
    endproperty
    a_settle: assert property (p_settle) else $error("settle count wrong");

    property p_clipPos;
        (convTick && (SCL_W'(comb3[0]) <<< shiftNow) > $signed({{(SCL_W-OUT_W){1'b0}}, POS_FULL}))
            |=> resultData[OUT_W-1:0] == POS_FULL;
    endproperty
    a_clipPos: assert property (p_clipPos) else $error("positive clip missing");

    property p_clipNeg;
        (convTick && (SCL_W'(comb3[1]) <<< shiftNow) <= $signed({{(SCL_W-OUT_W){1'b1}}, NEG_FULL}))
            |=> resultData[OUT_W +: OUT_W] == NEG_FULL;
    endproperty
    a_clipNeg: assert property (p_clipNeg) else $error("negative clip missing");

    property p_format;
        (convTick && comb3[2] == '0) |=> resultData[2*OUT_W +: OUT_W] == '0;
    endproperty
    a_format: assert property (p_format) else $error("zero not coded as zero");

    property p_restart;
        restart |=> !dataSettled && !resultValid;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear");

endmodule // dcf_top

// ==== dv/dcf_mod_model.sv ====
// Purpose: modulator bitstream source for the decimation block
// Assumes: channel c carries pattern c mod 3: ones, zeros, alternating
// Notes:   alternating bit flips after each modulator tick
module dcf_mod_model
    import dcf_pkg::*;
#(
    parameter int NCH = 8
)(
    input  wire logic           core_clk,
    input  wire logic           modulatorRate,
    output logic [NCH-1:0]      modBits
);
    timeunit 1ns;
    timeprecision 1ps;
    logic alt = 1'b0;
    always @(negedge core_clk)
        if (modulatorRate === 1'b1)
            alt <= ~alt;
    always_comb
        for (int c = 0; c < NCH; c++)
            modBits[c] = (c % 3 == 0) ? 1'b1 : (c % 3 == 1) ? 1'b0 : alt;
endmodule // dcf_mod_model

// ==== dv/dcf_top_tb.sv ====
// Purpose: self-checking bench of the decimation and output format block
// Assumes: inputs driven at falling edge, outputs sampled there
// Notes:   sinc3 values checked only for constant and alternating streams
module dcf_top_tb
    import dcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               core_clk = 1'b0;
    logic               resetn = 1'b0;
    logic [1:0]         modeSel = 2'h0;
    logic               clockDivideSelect = 1'b0;
    logic [7:0]         modBits;
    logic               modulatorRate;
    logic [191:0]       resultData;
    logic               resultValid;
    logic               dataSettled;
    int                 errors = 0;
    int                 checksDone = 0;
    int                 cycles = 0;
    dcf_top u_dcf_top (.core_clk(core_clk), .resetn(resetn), .modeSel(modeSel),
        .clockDivideSelect(clockDivideSelect), .modBits(modBits), .modulatorRate(modulatorRate),
        .resultData(resultData), .resultValid(resultValid), .dataSettled(dataSettled));
    dcf_mod_model u_dcf_mod_model (.core_clk(core_clk), .modulatorRate(modulatorRate), .modBits(modBits));
    initial forever #2.5 core_clk = ~core_clk;
    task automatic reportAndStop();
        $display("checks %0d errors %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 100000)
        begin
            errors++;
            reportAndStop();
        end
    end
    task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
        checksDone++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic set_mode(logic [1:0] m, logic d);
        @(negedge core_clk);
        modeSel = m;
        clockDivideSelect = d;
    endtask
    task automatic wait_valid();
        do @(negedge core_clk); while (resultValid !== 1'b1);
    endtask
    task automatic check_rate(logic [1:0] m, logic d, int f, int osr);
        int n;
        set_mode(m, d);
        do @(negedge core_clk); while (modulatorRate !== 1'b1);
        n = 0;
        do begin @(negedge core_clk); n++; end while (modulatorRate !== 1'b1);
        chk("tick spacing", 24'(f), 24'(n));
        wait_valid();
        n = 0;
        do begin @(negedge core_clk); if (modulatorRate === 1'b1) n++; end while (resultValid !== 1'b1);
        chk("ticks per result", 24'(osr), 24'(n));
    endtask
    task automatic check_settle(logic [1:0] m, int s);
        int n;
        set_mode(m, 1'b1);
        @(negedge core_clk);
        @(negedge core_clk);
        chk("settled after restart", 24'h0, {23'h0, dataSettled});
        n = 0;
        do begin @(negedge core_clk); if (resultValid === 1'b1) n++; end while (dataSettled !== 1'b1);
        chk("settle count", 24'(s), 24'(n));
    endtask
    task automatic check_values();
        logic signed [23:0] v;
        wait_valid();
        for (int c = 0; c < 8; c++)
        begin
            v = resultData[c*24 +: 24];
            if (c % 3 == 0)
                chk("full scale high", POS_FULL, v);
            else if (c % 3 == 1)
                chk("full scale low", NEG_FULL, v);
            else
                // tone at half the modulator rate must sit 100 dB below full scale
                chk("midscale small", 24'h1, {23'h0, (v < 24'sh54 && v > -24'sh54)});
        end
    endtask
    initial
    begin
        repeat (10) @(negedge core_clk);
        resetn = 1'b1;
        check_rate(MODE_HS, 1'b0, 4, 64);
        check_rate(MODE_HR, 1'b1, 4, 128);
        check_rate(MODE_LP, 1'b1, 8, 64);
        check_rate(MODE_LP, 1'b0, 4, 64);
        check_rate(MODE_LS, 1'b1, 40, 64);
        check_rate(MODE_LS, 1'b0, 8, 64);
        check_settle(MODE_HR, 78);
        check_values();
        check_settle(MODE_HS, 76);
        check_values();
        reportAndStop();
    end
endmodule // dcf_top_tb
